//--- src/gpr_consts.svh
/*
  Register indices, field positions, reset values and bus timing for the
  eight-pin port register block. Byte address of a register is four times
  its index. Assumes nothing of its surroundings.
*/
`ifndef GPR_CONSTS_SVH
`define GPR_CONSTS_SVH

`define GPR_IDX_DRIVE       6'h04
`define GPR_IDX_SET         6'h05
`define GPR_IDX_CLR         6'h06
`define GPR_IDX_TGL         6'h07
`define GPR_IDX_READBACK    6'h08
`define GPR_IDX_PRIO        6'h09
`define GPR_IDX_MASK0       6'h0a
`define GPR_IDX_MASK1       6'h0b
`define GPR_IDX_PENDING     6'h0c
`define GPR_IDX_REMAP       6'h0e
`define GPR_IDX_PINCFG      6'h10
`define GPR_PINCFG_SEL      3'b010

`define GPR_RST_VAL         8'h00
`define GPR_PRIO_BITS       4
`define GPR_REMAP_BITS      6
`define GPR_PINCFG_BITS     7

`define GPR_POLARITY_SWAP_BIT       6
`define GPR_OPC_HI          5
`define GPR_OPC_LO          3
`define GPR_ISC_HI          2
`define GPR_ISC_LO          0
`define GPR_REMAP_SPI_BIT   5
`define GPR_REMAP_USART_BIT 4
`define GPR_SPI_SCK_POS     3
`define GPR_SPI_MOSI_POS    1

`define GPR_WAIT_STATES     1

`endif

//--- src/gpr_pkg.sv
/*
  Types shared by the port register block: pad sense and drive styles.
  Assumes the constants header is compiled alongside.
*/
package gpr_pkg;

  typedef enum logic [2:0] {
    GPR_SENSE_BOTH    = 3'b000,
    GPR_SENSE_RISE    = 3'b001,
    GPR_SENSE_FALL    = 3'b010,
    GPR_SENSE_LOW     = 3'b011,
    GPR_SENSE_OFF     = 3'b111
  } gpr_sense_type;

  typedef enum logic [2:0] {
    GPR_OPC_TOTEM     = 3'b000,
    GPR_OPC_KEEPER    = 3'b001,
    GPR_OPC_PULLDN    = 3'b010,
    GPR_OPC_PULLUP    = 3'b011,
    GPR_OPC_WOR       = 3'b100,
    GPR_OPC_WAND      = 3'b101,
    GPR_OPC_WOR_PULL  = 3'b110,
    GPR_OPC_WAND_PULL = 3'b111
  } gpr_opc_type;

endpackage

//--- src/gpr_sense.sv
/*
  Pad input sampler: two-flop synchroniser, polarity inversion, input
  buffer disable and per-pad sense detection.
  Assumes pad_in is asynchronous and all other inputs are on clk.
*/
`timescale 1ns/1ns
`default_nettype none

module gpr_sense
  import gpr_pkg::*;
(
  input  wire logic        clk,        // Peripheral clock
  input  wire logic        rst_n,      // Asynchronous reset, active low
  input  wire logic [7:0]  pad_in,     // Raw pad levels
  input  wire logic [7:0]  invert,     // Per-pad polarity swap
  input  wire logic [23:0] sense,      // Per-pad sense codes, 3 bits each
  output logic      [7:0]  level_r,    // Sampled, inverted levels
  output logic      [7:0]  hit         // Per-pad sense match this cycle
);

  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] prev_r;
  logic [7:0] armed_r;
  logic [7:0] enabled;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      enabled[i] = sense[3*i +: 3] != GPR_SENSE_OFF;
    end
  end

  // Disabled pads stop sampling and read back zero [R8] [R20]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= 8'h00;
      prev_r  <= 8'h00;
      armed_r <= 8'h00;
    end else begin
      level_r <= (sync2_r ^ invert) & enabled;
      prev_r  <= level_r;
      armed_r <= enabled;
    end
  end

  // Armed one cycle after enabling, while prev_r still holds zero, so a high pad can fake an edge
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      unique case (sense[3*i +: 3])
        GPR_SENSE_BOTH: hit[i] = level_r[i] ^ prev_r[i];      // [R23]
        GPR_SENSE_RISE: hit[i] = level_r[i] & ~prev_r[i];     // [R23]
        GPR_SENSE_FALL: hit[i] = ~level_r[i] & prev_r[i];     // [R23]
        GPR_SENSE_LOW:  hit[i] = ~level_r[i];                 // [R23]
        default:        hit[i] = 1'b0;
      endcase
      hit[i] = hit[i] & armed_r[i] & enabled[i];              // [R22]
    end
  end

endmodule

`default_nettype wire

//--- src/gpr_top.sv
/*
  Eight-pin port register block: drive level with set/clear/toggle
  strobes, input readback, two port interrupts, alternate-pin remap and
  per-pad configuration, reached over APB.
  Assumes direction and alternate-function requests arrive on pclk and
  that the pad ring resolves pad_out/pad_oe and the pull enables.
*/
// Function
// R1 - Pad is driven to the stored drive level bit.
// R2 - Drive level reaches the pad only when the pad is an output.
// R3 - Set strobe sets drive bits written as one.
// R4 - Clear strobe clears drive bits written as one.
// R5 - Toggle strobe inverts drive bits written as one.
// R6 - Strobe addresses read back the drive level.
// R7 - Readback shows sampled pad levels while the input buffer is on.
// R8 - Disabled input buffer stops sampling; readback ignores the pad.
// R9 - Priority register holds two 2-bit level fields, bits 3:2 and 1:0.
// R10 - Software writes zero to reserved bits.
// R11 - Source select 0 picks pads feeding interrupt 0.
// R12 - Source select 1 picks pads feeding interrupt 1.
// R13 - Pending flag sets on a sense match of a selected pad.
// R14 - Writing one clears a pending flag; zero leaves it.
// R15 - Remap bit swaps clock and data-out pads of the serial unit.
// R16 - Serial unit move shifts its pads from low to high nibble.
// R17 - Each compare move shifts compare output k to pin k+4.
// R18 - Shared pad carries the OR of both timers' waveforms.
// R19 - Remap register exists only on ports that offer it.
// R20 - Polarity swap inverts both output and input data.
// R21 - Drive/pull field selects totem, keeper, pulls and wired modes.
// R22 - Sense field decides which pad condition triggers interrupts.
// R23 - Sense codes: both, rising, falling, low level, buffer off.
// R24 - Direction bit one makes the pad an output.
// R25 - Interrupt request while flag set and its level field nonzero.
// R26 - All registers reset to zero.
`timescale 1ns/1ns
`default_nettype none
`include "gpr_consts.svh"

module gpr_top
  import gpr_pkg::*;
#(
  parameter bit REMAP_PRESENT = 1'b1
)(
  input  wire logic        pclk,          // Peripheral clock, 25 MHz
  input  wire logic        presetn,       // Asynchronous reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB access phase
  input  wire logic        pwrite,        // APB write
  input  wire logic [7:0]  paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error, unmapped address
  input  wire logic [7:0]  pad_in,        // Pad levels from the pins
  input  wire logic [7:0]  pad_dir,       // Direction, one is output
  output logic      [7:0]  pad_out,       // Value driven to each pad
  output logic      [7:0]  pad_oe,        // Pad output enable
  output logic      [7:0]  pad_pullup_en, // Pull-up enable
  output logic      [7:0]  pad_pulldn_en, // Pull-down enable
  output logic      [7:0]  pad_keeper_en, // Bus-keeper enable
  input  wire logic [3:0]  tmr0_cmp_val,  // Timer 0 compare A..D waves
  input  wire logic [3:0]  tmr0_cmp_en,   // Timer 0 compare A..D active
  input  wire logic [1:0]  tmr1_cmp_val,  // Timer 1 compare A..B waves
  input  wire logic [1:0]  tmr1_cmp_en,   // Timer 1 compare A..B active
  input  wire logic [3:0]  usart_val,     // Serial unit 0 pad values
  input  wire logic [3:0]  usart_en,      // Serial unit 0 pad overrides
  output logic      [1:0]  irq_req,       // Port interrupt requests
  output logic      [3:0]  irq_level      // Priority fields, 3:2 and 1:0
);

  logic [7:0]  drive_level_r;
  logic [7:0]  drive_level_nxt;
  logic [3:0]  prio_r;
  logic [7:0]  mask0_r;
  logic [7:0]  mask1_r;
  logic [1:0]  pending_r;
  logic [1:0]  pending_nxt;
  logic [5:0]  remap_r;
  logic [6:0]  pincfg_r [8];
  logic [7:0]  level_w;
  logic [7:0]  hit_w;
  logic [7:0]  invert_w;
  logic [23:0] sense_w;
  logic [5:0]  idx;
  logic        wr_en;
  logic [7:0]  wd;
  logic [7:0]  alt_en;
  logic [7:0]  alt_val;
  logic [3:0]  usart_nib_val;
  logic [3:0]  usart_nib_en;
  logic [7:0]  out_nxt;
  logic [7:0]  oe_nxt;
  logic [7:0]  pu_nxt;
  logic [7:0]  pd_nxt;
  logic [7:0]  kp_nxt;
  logic [1:0]  set_w;

  assign idx   = paddr[7:2];
  assign wd    = pwdata[7:0];
  assign wr_en = psel & penable & pready & pwrite;

  function automatic logic is_pincfg(input logic [5:0] a);
    return a[5:3] == `GPR_PINCFG_SEL;
  endfunction

  function automatic logic addr_ok(input logic [5:0] a);
    unique case (a)
      `GPR_IDX_DRIVE, `GPR_IDX_SET, `GPR_IDX_CLR, `GPR_IDX_TGL,
      `GPR_IDX_READBACK, `GPR_IDX_PRIO, `GPR_IDX_MASK0,
      `GPR_IDX_MASK1, `GPR_IDX_PENDING, `GPR_IDX_REMAP: return 1'b1;
      default: return is_pincfg(a);
    endcase
  endfunction

  // Read value of a register; narrow data in the low bits
  function automatic logic [7:0] read_reg(input logic [5:0] a);
    if (is_pincfg(a)) begin
      return {1'b0, pincfg_r[a[2:0]]};
    end
    unique case (a)
      `GPR_IDX_DRIVE,
      `GPR_IDX_SET,
      `GPR_IDX_CLR,
      `GPR_IDX_TGL:      return drive_level_r;               // [R6]
      `GPR_IDX_READBACK: return level_w;                     // [R7]
      `GPR_IDX_PRIO:     return {4'h0, prio_r};              // [R9]
      `GPR_IDX_MASK0:    return mask0_r;
      `GPR_IDX_MASK1:    return mask1_r;
      `GPR_IDX_PENDING:  return {6'h00, pending_r};
      `GPR_IDX_REMAP:    return {2'h0, remap_r};
      default:           return `GPR_RST_VAL;
    endcase
  endfunction

  // One wait state: pready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok(idx);
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= {24'h00_0000, read_reg(idx)};
      end
    end
  end

  always_comb begin
    drive_level_nxt = drive_level_r;
    if (wr_en) begin
      unique case (idx)
        `GPR_IDX_DRIVE: drive_level_nxt = wd;                     // [R1]
        `GPR_IDX_SET:   drive_level_nxt = drive_level_r | wd;     // [R3]
        `GPR_IDX_CLR:   drive_level_nxt = drive_level_r & ~wd;    // [R4]
        `GPR_IDX_TGL:   drive_level_nxt = drive_level_r ^ wd;     // [R5]
        default:        drive_level_nxt = drive_level_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_level_r <= `GPR_RST_VAL;                              // [R26]
    end else begin
      drive_level_r <= drive_level_nxt;
    end
  end

  // Reserved bits are not stored and read as zero [R10]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_r  <= 4'h0;                                            // [R26]
      mask0_r <= `GPR_RST_VAL;
      mask1_r <= `GPR_RST_VAL;
      remap_r <= 6'h00;
    end else if (wr_en) begin
      if (idx == `GPR_IDX_PRIO) begin
        prio_r <= wd[`GPR_PRIO_BITS-1:0];                         // [R9]
      end
      if (idx == `GPR_IDX_MASK0) begin
        mask0_r <= wd;
      end
      if (idx == `GPR_IDX_MASK1) begin
        mask1_r <= wd;
      end
      if (idx == `GPR_IDX_REMAP && REMAP_PRESENT) begin
        remap_r <= wd[`GPR_REMAP_BITS-1:0];                       // [R19]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        pincfg_r[i] <= 7'h00;                                     // [R26]
      end
    end else if (wr_en && is_pincfg(idx)) begin
      pincfg_r[idx[2:0]] <= wd[`GPR_PINCFG_BITS-1:0];
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      invert_w[i]       = pincfg_r[i][`GPR_POLARITY_SWAP_BIT];
      sense_w[3*i +: 3] = pincfg_r[i][`GPR_ISC_HI:`GPR_ISC_LO];
    end
  end

  gpr_sense u_sense (
    .clk     (pclk),
    .rst_n   (presetn),
    .pad_in  (pad_in),
    .invert  (invert_w),
    .sense   (sense_w),
    .level_r (level_w),
    .hit     (hit_w)
  );

  assign set_w = {|(hit_w & mask1_r), |(hit_w & mask0_r)};   // [R11] [R12]

  // A sense match in the clearing cycle keeps the flag set [R13] [R14]
  always_comb begin
    pending_nxt = pending_r;
    if (wr_en && idx == `GPR_IDX_PENDING) begin
      pending_nxt = pending_r & ~wd[1:0];
    end
    pending_nxt = pending_nxt | set_w;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_r <= 2'b00;
      irq_req   <= 2'b00;
      irq_level <= 4'h0;
    end else begin
      pending_r <= pending_nxt;
      irq_req   <= {pending_r[1] & (|prio_r[3:2]),
                    pending_r[0] & (|prio_r[1:0])};               // [R25]
      irq_level <= prio_r;
    end
  end

  // Alternate functions; serial unit overrides win over timer outputs
  always_comb begin
    usart_nib_val = usart_val;
    usart_nib_en  = usart_en;
    if (remap_r[`GPR_REMAP_SPI_BIT]) begin                        // [R15]
      usart_nib_val[`GPR_SPI_SCK_POS]  = usart_val[`GPR_SPI_MOSI_POS];
      usart_nib_val[`GPR_SPI_MOSI_POS] = usart_val[`GPR_SPI_SCK_POS];
      usart_nib_en[`GPR_SPI_SCK_POS]   = usart_en[`GPR_SPI_MOSI_POS];
      usart_nib_en[`GPR_SPI_MOSI_POS]  = usart_en[`GPR_SPI_SCK_POS];
    end
    alt_en  = {6'h00, tmr1_cmp_en} << 4;
    alt_val = {6'h00, tmr1_cmp_val & tmr1_cmp_en} << 4;
    for (int k = 0; k < 4; k++) begin
      if (remap_r[k]) begin                                 // [R17] [R18]
        alt_en[k+4]  = alt_en[k+4] | tmr0_cmp_en[k];
        alt_val[k+4] = alt_val[k+4] | (tmr0_cmp_val[k] & tmr0_cmp_en[k]);
      end else begin                                              // [R17]
        alt_en[k]  = tmr0_cmp_en[k];
        alt_val[k] = tmr0_cmp_val[k] & tmr0_cmp_en[k];
      end
    end
    for (int k = 0; k < 4; k++) begin
      if (remap_r[`GPR_REMAP_USART_BIT]) begin                    // [R16]
        if (usart_nib_en[k]) begin
          alt_en[k+4]  = 1'b1;
          alt_val[k+4] = usart_nib_val[k];
        end
      end else if (usart_nib_en[k]) begin
        alt_en[k]  = 1'b1;
        alt_val[k] = usart_nib_val[k];
      end
    end
  end

  // Pad drive and pull style per pad
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      out_nxt[i] = (alt_en[i] ? alt_val[i] : drive_level_r[i])
                   ^ invert_w[i];                                 // [R1] [R20]
      pu_nxt[i]  = 1'b0;
      pd_nxt[i]  = 1'b0;
      kp_nxt[i]  = 1'b0;
      unique case (pincfg_r[i][`GPR_OPC_HI:`GPR_OPC_LO])          // [R21]
        GPR_OPC_TOTEM:     oe_nxt[i] = pad_dir[i];
        GPR_OPC_KEEPER: begin
          oe_nxt[i] = pad_dir[i];
          kp_nxt[i] = 1'b1;
        end
        GPR_OPC_PULLDN: begin
          oe_nxt[i] = pad_dir[i];
          pd_nxt[i] = ~pad_dir[i];
        end
        GPR_OPC_PULLUP: begin
          oe_nxt[i] = pad_dir[i];
          pu_nxt[i] = ~pad_dir[i];
        end
        GPR_OPC_WOR:       oe_nxt[i] = pad_dir[i] & out_nxt[i];
        GPR_OPC_WAND:      oe_nxt[i] = pad_dir[i] & ~out_nxt[i];
        GPR_OPC_WOR_PULL: begin
          oe_nxt[i] = pad_dir[i] & out_nxt[i];
          pd_nxt[i] = 1'b1;
        end
        GPR_OPC_WAND_PULL: begin
          oe_nxt[i] = pad_dir[i] & ~out_nxt[i];
          pu_nxt[i] = 1'b1;
        end
      endcase
    end
  end

  // Direction one passes oe_nxt to the driver; zero leaves the pad undriven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out       <= 8'h00;
      pad_oe        <= 8'h00;
      pad_pullup_en <= 8'h00;
      pad_pulldn_en <= 8'h00;
      pad_keeper_en <= 8'h00;
    end else begin
      pad_out       <= out_nxt;
      pad_oe        <= oe_nxt & pad_dir;                          // [R2] [R24]
      pad_pullup_en <= pu_nxt;
      pad_pulldn_en <= pd_nxt;
      pad_keeper_en <= kp_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr(logic [5:0] a);
    psel && penable && pready && pwrite && paddr[7:2] == a;
  endsequence

  sequence s_rd_first(logic [5:0] a);
    psel && penable && !pready && !pwrite && paddr[7:2] == a;
  endsequence

  property p_set;
    s_wr(`GPR_IDX_SET) |=>
      drive_level_r == ($past(drive_level_r) | $past(pwdata[7:0]));
  endproperty
  a_set: assert property (p_set) else $error("set strobe wrong"); // [R3]

  property p_clr;
    s_wr(`GPR_IDX_CLR) |=>
      drive_level_r == ($past(drive_level_r) & ~$past(pwdata[7:0]));
  endproperty
  a_clr: assert property (p_clr) else $error("clr strobe wrong"); // [R4]

  property p_tgl;
    s_wr(`GPR_IDX_TGL) |=>
      drive_level_r == ($past(drive_level_r) ^ $past(pwdata[7:0]));
  endproperty
  a_tgl: assert property (p_tgl) else $error("tgl strobe wrong"); // [R5]

  property p_rd_strobe;
    s_rd_first(`GPR_IDX_TGL) |=>
      pready && prdata[7:0] == $past(drive_level_r);
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) // [R6]
    else $error("strobe read wrong");

  property p_oe_dir;
    1'b1 |=> (pad_oe & ~$past(pad_dir)) == 8'h00;
  endproperty
  a_oe_dir: assert property (p_oe_dir) // [R2]
    else $error("input pad driven");

  property p_drive;
    pad_dir[0] && pincfg_r[0] == 7'h00 && !alt_en[0] |=>
      pad_oe[0] && pad_out[0] == $past(drive_level_r[0]);
  endproperty
  a_drive: assert property (p_drive) // [R1]
    else $error("pad not driven to level");

  property p_flag_set;
    hit_w[0] && mask0_r[0] |=>
      pending_r[0];
  endproperty
  a_flag_set: assert property (p_flag_set) // [R13]
    else $error("flag not set");

  property p_flag_clr;
    s_wr(`GPR_IDX_PENDING) ##0 pwdata[1] && !set_w[1] |=> !pending_r[1];
  endproperty
  a_flag_clr: assert property (p_flag_clr) // [R14]
    else $error("flag not cleared");

  property p_irq;
    1'b1 |=> irq_req == {$past(pending_r[1]) && $past(prio_r[3:2]) != 2'b00,
                         $past(pending_r[0]) && $past(prio_r[1:0]) != 2'b00};
  endproperty
  a_irq: assert property (p_irq) else $error("irq request wrong"); // [R25]

  property p_dis;
    pincfg_r[1][2:0] == GPR_SENSE_OFF [*2] |-> !level_w[1] && !hit_w[1];
  endproperty
  a_dis: assert property (p_dis) // [R8]
    else $error("disabled pad sampled");

  property p_prio_rsv;
    s_rd_first(`GPR_IDX_PRIO) |=> prdata[7:4] == 4'h0
      && prdata[3:0] == $past(prio_r);
  endproperty
  a_prio_rsv: assert property (p_prio_rsv) // [R9]
    else $error("priority read wrong");

endmodule

`default_nettype wire

//--- testbench/gpr_pad_model.sv
/*
  Pad ring and board model: resolves each pin from the block's drive,
  an outside driver of the bench, pulls and keeper, and feeds pad_in.
  Assumes all controls are levels on pclk.
*/
`timescale 1ns/1ns
`default_nettype none

module gpr_pad_model (
  input  wire logic       pclk,          // Peripheral clock
  input  wire logic [7:0] pad_out,       // Block drive value
  input  wire logic [7:0] pad_oe,        // Block drive enable
  input  wire logic [7:0] pad_pullup_en, // Pull-up on
  input  wire logic [7:0] pad_pulldn_en, // Pull-down on
  input  wire logic [7:0] pad_keeper_en, // Keeper on
  input  wire logic [7:0] ext_val,       // Board drive value
  input  wire logic [7:0] ext_en,        // Board drive enable
  output logic      [7:0] pad_in         // Resolved pin levels
);
  logic [7:0] float_r;
  logic [7:0] hold_r;

  initial float_r = 8'h55;

  // A pin nobody drives wanders, so stale values are never seen
  always @(posedge pclk) begin
    float_r <= ~float_r;
    hold_r  <= pad_in;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_pullup_en[i])
        pad_in[i] = 1'b1;
      else if (pad_pulldn_en[i])
        pad_in[i] = 1'b0;
      else if (pad_keeper_en[i])
        pad_in[i] = hold_r[i];
      else
        pad_in[i] = float_r[i];
    end
  end
endmodule

`default_nettype wire

//--- testbench/tb.sv
/*
  Self-checking bench for the port register block, driven over APB.
  Assumes the pad model closes the loop from pad controls to pad_in.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, pad_dir, pad_in, pad_out, pad_oe, ext_val, ext_en;
  logic [7:0]  pad_pullup_en, pad_pulldn_en, pad_keeper_en, rd;
  logic [31:0] pwdata, prdata;
  logic [3:0]  tmr0_cmp_val, tmr0_cmp_en, usart_val, usart_en, irq_level;
  logic [1:0]  tmr1_cmp_val, tmr1_cmp_en, irq_req;
  logic        err_r;
  int          errors, cmp_count;

  gpr_top gpr_top_inst (.*);
  gpr_pad_model gpr_pad_model_inst (.*);

  always #20 pclk = ~pclk;

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [5:0] idx,
                     input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err_r = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [5:0] idx,
                      input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(nm, e, rd);
  endtask

  task automatic t_reset;
    logic [5:0] ids [11] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09,
                             6'h0a, 6'h0b, 6'h0c, 6'h0e, 6'h10};
    foreach (ids[i]) rchk("reset value", ids[i], 8'h00);
    chk("irq_req at reset", 8'h00, {6'h0, irq_req});
    apb(1'b0, 6'h3f, 8'h00);
    chk("pslverr unmapped", 8'h01, {7'h0, err_r});
    $display("test reset done");
  endtask

  task automatic t_drive;
    pad_dir <= 8'hff;
    apb(1'b1, 6'h04, 8'h5a);
    apb(1'b1, 6'h05, 8'h81);
    rchk("after set", 6'h04, 8'hdb);
    apb(1'b1, 6'h06, 8'h0a);
    rchk("after clear", 6'h04, 8'hd1);
    apb(1'b1, 6'h07, 8'hff);
    rchk("set addr read", 6'h05, 8'h2e);
    rchk("clear addr read", 6'h06, 8'h2e);
    rchk("toggle addr read", 6'h07, 8'h2e);
    chk("pad_out drive", 8'h2e, pad_out);
    pad_dir <= 8'h0f;
    repeat (3) @(posedge pclk);
    chk("pad_oe by direction", 8'h0f, pad_oe);
    $display("test drive done");
  endtask

  task automatic t_readback;
    pad_dir <= 8'h00;
    ext_val <= 8'ha7;
    apb(1'b1, 6'h10, 8'h40);
    apb(1'b1, 6'h11, 8'h07);
    repeat (5) @(posedge pclk);
    rchk("readback", 6'h08, 8'ha4);
    $display("test readback done");
  endtask

  task automatic t_irq;
    ext_val <= 8'h02;
    apb(1'b1, 6'h10, 8'h01);
    apb(1'b1, 6'h11, 8'h03);
    apb(1'b1, 6'h09, 8'h06);
    apb(1'b1, 6'h0a, 8'h01);
    chk("irq_level", 8'h06, {4'h0, irq_level});
    apb(1'b1, 6'h0b, 8'h02);
    apb(1'b1, 6'h0c, 8'h03);
    rchk("pending idle", 6'h0c, 8'h00);
    ext_val <= 8'h03;
    repeat (6) @(posedge pclk);
    rchk("pending rise", 6'h0c, 8'h01);
    ext_val <= 8'h01;
    repeat (6) @(posedge pclk);
    rchk("pending low", 6'h0c, 8'h03);
    chk("irq_req both", 8'h03, {6'h0, irq_req});
    apb(1'b1, 6'h0c, 8'h01);
    repeat (3) @(posedge pclk);
    rchk("pending w1c", 6'h0c, 8'h02);
    chk("irq_req one", 8'h02, {6'h0, irq_req});
    apb(1'b1, 6'h09, 8'h00);
    repeat (3) @(posedge pclk);
    chk("irq_req off", 8'h00, {6'h0, irq_req});
    $display("test irq done");
  endtask

  task automatic t_remap;
    logic [7:0] rm [4] = '{8'h00, 8'h01, 8'h10, 8'h30};
    logic [7:0] ex [4] = '{8'h01, 8'h10, 8'h21, 8'h81};
    pad_dir      <= 8'hff;
    tmr0_cmp_en  <= 4'h1;
    tmr0_cmp_val <= 4'h1;
    tmr1_cmp_en  <= 2'h1;
    usart_val    <= 4'h2;
    apb(1'b1, 6'h10, 8'h00);
    apb(1'b1, 6'h04, 8'h00);
    foreach (rm[i]) begin
      usart_en <= rm[i][4] ? 4'h2 : 4'h0;
      apb(1'b1, 6'h0e, rm[i]);
      repeat (3) @(posedge pclk);
      chk("pad_out remap", ex[i], pad_out);
    end
    rchk("remap read", 6'h0e, 8'h30);
    $display("test remap done");
  endtask

  task automatic t_pulls;
    pad_dir <= 8'h00;
    apb(1'b1, 6'h12, 8'h18);
    repeat (3) @(posedge pclk);
    chk("pull-up", 8'h04, pad_pullup_en);
    apb(1'b1, 6'h12, 8'h10);
    repeat (3) @(posedge pclk);
    chk("pull-down", 8'h04, pad_pulldn_en);
    apb(1'b1, 6'h12, 8'h08);
    repeat (3) @(posedge pclk);
    chk("keeper", 8'h04, pad_keeper_en);
    pad_dir <= 8'h04;
    apb(1'b1, 6'h12, 8'h28);
    repeat (3) @(posedge pclk);
    chk("wired-and oe", 8'h04, pad_oe);
    apb(1'b1, 6'h12, 8'h30);
    repeat (3) @(posedge pclk);
    chk("wired-or pull oe", 8'h00, pad_oe);
    chk("wired-or pull-down", 8'h04, pad_pulldn_en);
    $display("test pulls done");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite} = '0;
    {paddr, pwdata, pad_dir, ext_val} = '0;
    {tmr0_cmp_val, tmr0_cmp_en, tmr1_cmp_val, tmr1_cmp_en} = '0;
    {usart_val, usart_en} = '0;
    ext_en = 8'hff;
    errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_drive();
    t_readback();
    t_irq();
    t_remap();
    t_pulls();
    complete_run();
  end

  initial begin
    #800000;
    errors++;
    complete_run();
  end
endmodule

`default_nettype wire
